// ==== clk_ctrl_consts.vh ====
// Constants of the clock gating and programmable clock block.
// Assumes byte addresses on the APB and one-cycle source tick enables.
`ifndef CLK_CTRL_CONSTS_VH
`define CLK_CTRL_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_SCE 8'h00
`define OFS_SCD 8'h04
`define OFS_SCS 8'h08
`define OFS_PCE 8'h10
`define OFS_PCD 8'h14
`define OFS_PCS 8'h18
`define OFS_MOR 8'h20
`define OFS_MCF 8'h24
`define OFS_PLA 8'h28
`define OFS_PLB 8'h2c
`define OFS_MCK 8'h30
`define OFS_PK0 8'h40
`define OFS_PK1 8'h44
`define OFS_IEN 8'h60
`define OFS_IDS 8'h64
`define OFS_STS 8'h68
`define OFS_IMK 8'h6c
`define OFS_ICP 8'h80
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define RST_SCS 32'h00000003
`define RST_PLL 32'h00003f00
`define MSK_SCE 32'h000003c0
`define MSK_SCD 32'h000003c1
`define MSK_PID 32'h0007fffc
`define MSK_STS 32'h0000030f
`define MSK_CFG 32'h0000001f
`define MSK_MOR 32'h0000ff03
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_CPU 0
`define BIT_USB_HOST 6
`define BIT_USB_DEV 7
`define BIT_PRG 8
`define BIT_OSC_OK 0
`define BIT_LOCK_A 1
`define BIT_LOCK_B 2
`define BIT_MST_RDY 3
`define SRC_HI 1
`define PRE_HI 4
`define PRE_LO 2
`define LCNT_HI 13
`define LCNT_LO 8
// ----------------------------------------
// Switch timing in cycles of the named clock, and master source codes
// ----------------------------------------
`define SW_SLOW_TICKS 12'd5
`define SW_SCALE_TICKS 12'd64
`define SRC_SLOW 2'h0
`define SRC_MAIN 2'h1
`endif

// ==== clk_ctrl.v ====
// Clock gating, programmable clock outputs and master clock switching.
// Assumes every clock is a one-cycle tick enable on core_clk.
// How it works
// [R01] Two programmable outputs, switched by set/clear writes, shown in status.
// [R02] Programmable outputs stay off after reset until software enables them.
// [R03] Source select picks slow, main, PLL A or PLL B; slow after reset.
// [R04] Prescaler divides by 1 to 64 in powers of two; one after reset.
// [R05] Ready flag rises once an enabled output runs; software waits for it.
// [R06] Source and prescale are taken together in a single register write.
// [R07] Software disables, reconfigures, re-enables and waits before reuse.
// [R08] Seventeen peripheral clocks gated by set/clear writes, readable status.
// [R09] An enabled peripheral clock is the master clock gated.
// [R10] One in the host bit turns host clocks on; zero does nothing.
// [R11] One in the device bit turns device clock on; zero does nothing.
// [R12] Ones in bits 8 and 9 enable programmable outputs; zeros nothing.
// [R13] Master switch finishes within the bypassed prescaler worst case.
// [R14] Active master prescaler adds 64 ticks of the new clock.
// [R15] Switch to a PLL waits that PLL lock count in slow ticks.
// [R16] PLL to PLL switch waits no lock count, only slow ticks.
// [R17] One in a peripheral enable bit turns that clock on.
// [R18] Config holds source in bits 1:0 and prescale exponent in 4:2.
// [R19] Enable writes set, disable writes clear, zeros change nothing.
`timescale 1ns/10ps
`default_nettype none
`include "clk_ctrl_consts.vh"

module clk_ctrl (
    input wire core_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire slowTick,
    input wire mainTick,
    input wire pllATick,
    input wire pllBTick,
    input wire usbTick,
    input wire wakeUp,
    output reg masterClk,
    output reg cpuClk,
    output reg usbHostClk,
    output reg usbDevClk,
    output reg [31:0] periphClk,
    output wire progOut0,
    output wire progOut1
);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    localparam ST_IDLE = 4'h1;
    localparam ST_SLOW = 4'h2;
    localparam ST_LOCK = 4'h4;
    localparam ST_SCALE = 4'h8;

    reg [31:0] sysOn_q;
    reg [31:0] perOn_q;
    reg [31:0] mor_q;
    reg [31:0] mck_q;
    reg [31:0] imr_q;
    reg [3:0] swState_q;
    reg [11:0] swCnt_q;
    reg [1:0] curSrc_q;
    reg [2:0] curScale_q;
    reg [5:0] mDiv_q;
    reg mstReady_q;
    reg oscOk_q;
    reg [31:0] rdMux;
    reg rdHit;

    wire [3:0] srcTick;
    wire [1:0] pllLock;
    wire [1:0] progRdy;
    wire [63:0] pllCfgAll;
    wire [9:0] progCfgAll;
    wire [1:0] progPulse;
    wire [7:0] offs;
    wire setup;
    wire wr;
    wire [31:0] stsVal;
    wire [5:0] mMask;
    wire mTick;
    wire [1:0] newSrc;
    wire [2:0] newScale;
    wire tgtPll;
    wire curPll;
    wire [11:0] lockCnt;

    assign offs = paddr[7:0];
    assign setup = psel & ~penable;
    assign wr = psel & penable & pready & pwrite;
    assign srcTick = {pllBTick, pllATick, mainTick, slowTick};
    assign stsVal = {22'h0, progRdy, 4'h0, mstReady_q, pllLock, oscOk_q};

    always @* begin
        rdMux = 32'h0;
        rdHit = 1'b1;
        case (offs)
            `OFS_SCE, `OFS_SCD, `OFS_PCE, `OFS_PCD, `OFS_IEN, `OFS_IDS, `OFS_ICP: rdMux = 32'h0;
            `OFS_SCS: rdMux = sysOn_q;
            `OFS_PCS: rdMux = perOn_q;
            `OFS_MOR: rdMux = mor_q;
            `OFS_MCF: rdMux = 32'h0;
            `OFS_PLA: rdMux = pllCfgAll[31:0];
            `OFS_PLB: rdMux = pllCfgAll[63:32];
            `OFS_MCK: rdMux = mck_q;
            `OFS_PK0: rdMux = {27'h0, progCfgAll[4:0]};
            `OFS_PK1: rdMux = {27'h0, progCfgAll[9:5]};
            `OFS_STS: rdMux = stsVal;
            `OFS_IMK: rdMux = imr_q;
            default: rdHit = 1'b0;
        endcase
    end

    // No wait state: answer registered in the setup cycle
    always @(posedge core_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~rdHit;
            if (setup) begin
                prdata <= rdMux;
            end
        end
    end

    // ----------------------------------------
    // System and peripheral gates
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (!rst_n) begin
            // [R02] outputs start off
            sysOn_q <= `RST_SCS;
            perOn_q <= 32'h0;
            mor_q <= 32'h0;
            imr_q <= 32'h0;
            oscOk_q <= 1'b0;
        end else begin
            // [R19] [R10] [R11] [R12] set beats clear
            if (wr && offs == `OFS_SCE) begin
                sysOn_q <= sysOn_q | (pwdata & `MSK_SCE);
            end else if (wr && offs == `OFS_SCD) begin
                sysOn_q <= sysOn_q & ~(pwdata & `MSK_SCD);
            end
            if (wakeUp) begin
                sysOn_q[`BIT_CPU] <= 1'b1;
            end
            // [R08] [R17] peripheral gates
            if (wr && offs == `OFS_PCE) begin
                perOn_q <= perOn_q | (pwdata & `MSK_PID);
            end else if (wr && offs == `OFS_PCD) begin
                perOn_q <= perOn_q & ~(pwdata & `MSK_PID);
            end
            if (wr && offs == `OFS_MOR) begin
                mor_q <= pwdata & `MSK_MOR;
            end
            oscOk_q <= |mor_q[1:0];
            if (wr && offs == `OFS_IEN) begin
                imr_q <= imr_q | (pwdata & `MSK_STS);
            end else if (wr && offs == `OFS_IDS) begin
                imr_q <= imr_q & ~(pwdata & `MSK_STS);
            end
        end
    end

    // ----------------------------------------
    // PLL lock counters
    // ----------------------------------------
    genvar j;
    generate
        for (j = 0; j < 2; j = j + 1) begin : gPll
            reg [31:0] cfg_q;
            reg [5:0] cnt_q;
            reg lock_q;
            wire hit;
            assign hit = wr && offs == (j == 0 ? `OFS_PLA : `OFS_PLB);
            assign pllCfgAll[j*32 +: 32] = cfg_q;
            assign pllLock[j] = lock_q;
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    cfg_q <= `RST_PLL;
                    cnt_q <= 6'h0;
                    lock_q <= 1'b0;
                end else if (hit) begin
                    cfg_q <= pwdata;
                    cnt_q <= 6'h0;
                    lock_q <= 1'b0;
                end else if (!lock_q && slowTick) begin
                    if (cnt_q == cfg_q[`LCNT_HI:`LCNT_LO]) begin
                        lock_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 6'h1;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Master clock switching
    // ----------------------------------------
    assign newSrc = pwdata[`SRC_HI:0];
    assign newScale = pwdata[`PRE_HI:`PRE_LO];
    assign tgtPll = mck_q[`SRC_HI];
    assign curPll = curSrc_q[1];
    assign lockCnt = {6'h0, (mck_q[0] ? pllCfgAll[32+`LCNT_HI:32+`LCNT_LO]
                                      : pllCfgAll[`LCNT_HI:`LCNT_LO])};

    always @(posedge core_clk) begin
        if (!rst_n) begin
            mck_q <= 32'h0;
            swState_q <= ST_IDLE;
            swCnt_q <= 12'h0;
            curSrc_q <= `SRC_SLOW;
            curScale_q <= 3'h0;
            mstReady_q <= 1'b1;
        end else if (wr && offs == `OFS_MCK) begin
            mck_q <= pwdata & `MSK_CFG;
            if (newSrc != mck_q[`SRC_HI:0] || newScale != mck_q[`PRE_HI:`PRE_LO]) begin
                mstReady_q <= 1'b0;
                swCnt_q <= 12'h0;
                swState_q <= ST_SLOW;
            end
        end else begin
            case (swState_q)
                ST_IDLE: begin
                    swCnt_q <= 12'h0;
                end
                // [R13] slow tick handover
                ST_SLOW: begin
                    if (slowTick) begin
                        if (swCnt_q == `SW_SLOW_TICKS - 12'h1) begin
                            swCnt_q <= 12'h0;
                            // [R15] [R16] lock wait only from non-PLL
                            swState_q <= (tgtPll && !curPll) ? ST_LOCK : ST_SCALE;
                            curSrc_q <= tgtPll ? curSrc_q : mck_q[`SRC_HI:0];
                        end else begin
                            swCnt_q <= swCnt_q + 12'h1;
                        end
                    end
                end
                ST_LOCK: begin
                    if (slowTick) begin
                        if (swCnt_q >= lockCnt) begin
                            swCnt_q <= 12'h0;
                            swState_q <= ST_SCALE;
                        end else begin
                            swCnt_q <= swCnt_q + 12'h1;
                        end
                    end
                end
                // [R14] prescaler settling on new clock
                ST_SCALE: begin
                    curSrc_q <= mck_q[`SRC_HI:0];
                    curScale_q <= mck_q[`PRE_HI:`PRE_LO];
                    if (mck_q[`PRE_HI:`PRE_LO] == 3'h0) begin
                        mstReady_q <= 1'b1;
                        swState_q <= ST_IDLE;
                    end else if (srcTick[mck_q[`SRC_HI:0]]) begin
                        if (swCnt_q == `SW_SCALE_TICKS - 12'h1) begin
                            mstReady_q <= 1'b1;
                            swState_q <= ST_IDLE;
                        end else begin
                            swCnt_q <= swCnt_q + 12'h1;
                        end
                    end
                end
                default: begin
                    swState_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Master tick and gated outputs
    // ----------------------------------------
    assign mMask = ~(6'h3f << curScale_q);
    assign mTick = srcTick[curSrc_q] && ((mDiv_q & mMask) == mMask);

    always @(posedge core_clk) begin
        if (!rst_n) begin
            mDiv_q <= 6'h0;
            masterClk <= 1'b0;
            cpuClk <= 1'b0;
            usbHostClk <= 1'b0;
            usbDevClk <= 1'b0;
            periphClk <= 32'h0;
        end else begin
            if (srcTick[curSrc_q]) begin
                mDiv_q <= mDiv_q + 6'h1;
            end
            masterClk <= mTick;
            cpuClk <= mTick & sysOn_q[`BIT_CPU];
            usbHostClk <= usbTick & sysOn_q[`BIT_USB_HOST];
            usbDevClk <= usbTick & sysOn_q[`BIT_USB_DEV];
            // [R09] gated master copy
            periphClk <= {32{mTick}} & perOn_q;
        end
    end

    // ----------------------------------------
    // Programmable clock outputs
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : gProg
            reg [4:0] cfg_q;
            reg [5:0] div_q;
            reg out_q;
            reg rdy_q;
            wire on;
            wire tick;
            wire [5:0] mask;
            wire hit;
            assign hit = wr && offs == (i == 0 ? `OFS_PK0 : `OFS_PK1);
            // [R01] output enable from system status
            assign on = sysOn_q[`BIT_PRG + i];
            // [R03] source select
            assign tick = srcTick[cfg_q[`SRC_HI:0]];
            // [R04] power of two divider
            assign mask = ~(6'h3f << cfg_q[`PRE_HI:`PRE_LO]);
            assign progCfgAll[i*5 +: 5] = cfg_q;
            assign progPulse[i] = out_q;
            assign progRdy[i] = rdy_q;
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    cfg_q <= 5'h0;
                    div_q <= 6'h0;
                    out_q <= 1'b0;
                    rdy_q <= 1'b0;
                end else begin
                    // [R06] [R18] whole config at once
                    if (hit) begin
                        cfg_q <= pwdata[`PRE_HI:0];
                    end
                    if (!on || hit) begin
                        div_q <= 6'h0;
                    end else if (tick) begin
                        div_q <= div_q + 6'h1;
                    end
                    out_q <= on && tick && ((div_q & mask) == mask);
                    // [R05] ready after first output tick
                    if (on && out_q) begin
                        rdy_q <= 1'b1;
                    end else if (!on || hit) begin
                        rdy_q <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign progOut0 = progPulse[0];
    assign progOut1 = progPulse[1];

endmodule // clk_ctrl
`default_nettype wire

// ==== clk_ctrl_asserts.sv ====
// Port checker for clk_ctrl.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module clk_ctrl_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic slowTick,
    input wire logic mainTick,
    input wire logic pllATick,
    input wire logic pllBTick,
    input wire logic usbTick,
    input wire logic usbHostClk,
    input wire logic usbDevClk,
    input wire logic [31:0] periphClk,
    input wire logic progOut0,
    input wire logic progOut1
);
    wire anyTick;
    assign anyTick = slowTick | mainTick | pllATick | pllBTick;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ----
    // Bus phases
    // ----
    sequence setupS;
        psel && !penable;
    endsequence
    sequence readS(a);
        setupS ##0 (!pwrite && paddr[7:0] == a);
    endsequence
    apb_answer_a: assert property (setupS |=> pready)
        else $error("access phase without ready");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    unmapped_err_a: assert property (setupS ##0 paddr[7:0] == 8'h0c |=> pslverr)
        else $error("unmapped offset not refused");
    wo_read_zero_a: assert property (readS(8'h00) |=> prdata == 32'h0 && !pslverr)
        else $error("write-only register read not zero");
    reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !pready && !progOut0 && !progOut1)
        else $error("outputs active after reset");
    prog_tick_a: assert property (progOut0 || progOut1 |-> $past(anyTick))
        else $error("programmable pulse without source tick");
    periph_range_a: assert property (periphClk[1:0] == 2'h0 && periphClk[31:19] == 13'h0)
        else $error("unimplemented peripheral clock pulsed");
    usb_tick_a: assert property (usbHostClk || usbDevClk |-> $past(usbTick))
        else $error("usb clock without usb tick");
endmodule // clk_ctrl_asserts
bind clk_ctrl clk_ctrl_asserts i_clk_ctrl_asserts (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slowTick(slowTick), .mainTick(mainTick), .pllATick(pllATick), .pllBTick(pllBTick), .usbTick(usbTick),
    .usbHostClk(usbHostClk), .usbDevClk(usbDevClk), .periphClk(periphClk), .progOut0(progOut0),
    .progOut1(progOut1));
`default_nettype wire

// ==== clk_ctrl_tb.sv ====
// Self-checking bench for clk_ctrl over APB.
// Assumes clock ticks made here from a free cycle counter.
`timescale 1ns/10ps
`default_nettype none
module clk_ctrl_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0;
    logic slowTick = 1'b0, mainTick = 1'b0, pllATick = 1'b0, pllBTick = 1'b0, usbTick = 1'b0;
    logic wakeUp = 1'b0;
    wire [31:0] prdata, periphClk;
    wire pready, pslverr, usbHostClk, usbDevClk, progOut0, progOut1, masterClk, cpuClk;
    logic [31:0] rdData, tickCnt = 32'h0, cycles = 32'h0, pb;
    logic [35:0] seen;
    logic rdErr, sel;
    int error_cnt = 0, n_tests = 0, n;
    logic [7:0] rstA [9] = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h2c, 8'h30, 8'h40, 8'h68, 8'h6c};
    logic [31:0] rstV [9] = '{32'h0, 32'h3, 32'h0, 32'h3f00, 32'h3f00, 32'h0, 32'h0, 32'h8, 32'h0};
    logic [7:0] cfgTab [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h15, 8'h0d, 8'h18, 8'h1c};
    int ivTab [8] = '{8, 2, 4, 4, 64, 16, 512, 512};

    clk_ctrl i_clk_ctrl (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slowTick(slowTick), .mainTick(mainTick), .pllATick(pllATick),
        .pllBTick(pllBTick), .usbTick(usbTick), .wakeUp(wakeUp), .masterClk(masterClk), .cpuClk(cpuClk),
        .usbHostClk(usbHostClk), .usbDevClk(usbDevClk), .periphClk(periphClk),
        .progOut0(progOut0), .progOut1(progOut1));

    always #50 core_clk = ~core_clk;

    // ----
    // Ticks and timeout
    // ----
    always @(posedge core_clk) begin
        tickCnt <= tickCnt + 32'h1;
        slowTick <= tickCnt[2:0] == 3'h7;
        mainTick <= tickCnt[0];
        pllATick <= tickCnt[1:0] == 2'h1;
        pllBTick <= tickCnt[1:0] == 2'h3;
        usbTick <= tickCnt[0];
        cycles <= cycles + 32'h1;
        if (cycles == 32'd20000) begin
            error_cnt = error_cnt + 1;
            complete_run();
        end
    end

    // ----
    // Tasks
    // ----
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        check(nm, exp, rdData);
    endtask

    task automatic waitPulse(input logic s, input int lim, output int k);
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while ((s ? progOut1 : progOut0) !== 1'b1 && k < lim);
    endtask

    task automatic observe;
        seen = 36'h0;
        repeat (24) begin
            @(posedge core_clk);
            seen = seen | {masterClk, cpuClk, usbHostClk, usbDevClk, periphClk};
        end
    endtask

    task automatic mswitch(input logic [31:0] d, input int lo, input int hi);
        int k;
        k = 0;
        apb(1'b1, 8'h30, d);
        do begin
            apb(1'b0, 8'h68, 32'h0);
            k += 3;
        end while (rdData[3] !== 1'b1 && k < 600);
        check("switch time", 32'h1, {31'h0, k >= lo && k <= hi});
    endtask

    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ----
    // Main sequence
    // ----
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 9; i++) rd(rstA[i], rstV[i], "reset value");
        rd(8'h0c, 32'h0, "unmapped read");
        check("unmapped error", 32'h1, {31'h0, rdErr});
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'h0);
        rd(8'h08, 32'h3, "zero writes");
        $display("Test reset done");
        for (int i = 0; i < 8; i++) begin
            sel = i[0];
            pb = sel ? 32'h200 : 32'h100;
            apb(1'b1, 8'h04, pb);
            apb(1'b1, {5'h8, sel, 2'h0}, {24'h0, cfgTab[i]});
            rd({5'h8, sel, 2'h0}, {24'h0, cfgTab[i]}, "prog config");
            apb(1'b1, 8'h00, pb);
            n = 0;
            do begin
                apb(1'b0, 8'h68, 32'h0);
                n++;
            end while ((rdData & pb) == 32'h0 && n < 300);
            check("prog ready", pb, rdData & pb);
            waitPulse(sel, 1100, n);
            waitPulse(sel, 1100, n);
            check("prog interval", ivTab[i], n);
        end
        rd(8'h08, 32'h303, "both outputs on");
        apb(1'b1, 8'h04, 32'h300);
        rd(8'h08, 32'h3, "outputs off");
        waitPulse(1'b0, 600, n);
        check("prog stopped", 32'd600, n);
        $display("Test programmable clocks done");
        apb(1'b1, 8'h00, 32'hc0);
        rd(8'h08, 32'hc3, "usb on");
        observe();
        check("usb pulses", 2'h3, seen[33:32]);
        apb(1'b1, 8'h04, 32'h40);
        rd(8'h08, 32'h83, "host off");
        observe();
        check("usb after host off", 2'h1, seen[33:32]);
        $display("Test usb clocks done");
        apb(1'b1, 8'h10, 32'h110);
        rd(8'h18, 32'h110, "periph on");
        apb(1'b1, 8'h14, 32'h10);
        rd(8'h18, 32'h100, "periph off");
        observe();
        check("periph pulses", 32'h100, seen[31:0]);
        check("master pulses", 2'h3, seen[35:34]);
        apb(1'b1, 8'h10, 32'hffffffff);
        rd(8'h18, 32'h7fffc, "periph all");
        $display("Test peripheral clocks done");
        mswitch(32'h01, 27, 48);
        mswitch(32'h11, 155, 176);
        apb(1'b1, 8'h28, 32'h200);
        mswitch(32'h12, 305, 336);
        mswitch(32'h13, 280, 312);
        $display("Test master switch done");
        complete_run();
    end
endmodule // clk_ctrl_tb
`default_nettype wire
